// file: dv/ppom_periph_model.sv
`timescale 1ns/1ps
// =====================================================================
// Pin-change unit and converter as seen from the mux
// =====================================================================
module ppom_periph_model (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    // Settings requested by the bench
    input  wire logic [7:0] mask_req_i,
    input  wire logic       grp_req_i,
    input  wire logic [7:0] off_req_i,
    // Raw input tapped before the port synchronizer
    input  wire logic [7:0] pc_raw_i,
    // Own control bits and own synchronized copy
    output logic      [7:0] mask_o,
    output logic            grp_o,
    output logic      [7:0] off_o,
    output logic      [7:0] pc_sync_o
);
    logic [7:0] mask_q, mask_d, off_q, off_d, s1_q, s1_d, s2_q, s2_d;
    logic       grp_q, grp_d;

    // Each owner keeps its own control bits; the raw tap is async
    always_comb begin
        mask_d = mask_req_i;
        grp_d  = grp_req_i;
        off_d  = off_req_i;
        s1_d   = pc_raw_i;
        s2_d   = s1_q;
    end

    // Registers, cleared like the real owners
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {mask_q, grp_q, off_q, s1_q, s2_q} <= '0;
        end else begin
            {mask_q, grp_q, off_q, s1_q, s2_q} <=
                {mask_d, grp_d, off_d, s1_d, s2_d};
        end
    end

    assign {mask_o, grp_o, off_o, pc_sync_o} = {mask_q, grp_q, off_q, s2_q};
endmodule : ppom_periph_model

// file: dv/ppom_port_a_assertions.sv
`timescale 1ns/1ps
// =====================================================================
// Port-level checker for the Port A override mux
// =====================================================================
module ppom_port_a_chk #(
    parameter int unsigned PINS = 8
) (
    // Clock, reset and APB
    input wire logic            ref_clk_i,
    input wire logic            rst_b_i,
    input wire logic            psel_i,
    input wire logic            penable_i,
    input wire logic            pwrite_i,
    input wire logic [11:0]     paddr_i,
    input wire logic [31:0]     pwdata_i,
    input wire logic            pready_o,
    input wire logic            pslverr_o,
    // Pads, sleep, owners and taps
    input wire logic [PINS-1:0] pad_in_i,
    input wire logic [PINS-1:0] pad_out_o,
    input wire logic [PINS-1:0] pad_oe_o,
    input wire logic [PINS-1:0] pad_pullup_o,
    input wire logic [2:0]      sleep_mode_i,
    input wire logic [PINS-1:0] pin_change_mask_bits_i,
    input wire logic            pin_change_group0_en_i,
    input wire logic [PINS-1:0] chan_digital_off_bit_i,
    input wire logic [PINS-1:0] pin_change_src_o,
    input wire logic [PINS-1:0] converter_channels_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [PINS-1:0] ovr, sel, ien, wd_q, tog_q;

    // Expected input enable; an override wins over the sleep clamp
    always_comb begin
        ovr = pin_change_mask_bits_i & {PINS{pin_change_group0_en_i}};
        sel = ovr | chan_digital_off_bit_i;
        ien = (sel & ovr) |
              (~sel & {PINS{!(sleep_mode_i inside {3'h3, 3'h4, 3'h5})}});
    end

    // Write data and toggle result as they stood at the access edge
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wd_q  <= '0;
            tog_q <= '0;
        end else begin
            wd_q  <= pwdata_i[PINS-1:0];
            tog_q <= pad_out_o ^ (pwdata_i[PINS-1:0] & pad_oe_o);
        end
    end

    sequence s_setup; psel_i && !penable_i; endsequence
    sequence s_acc; psel_i && penable_i; endsequence
    sequence s_wr(logic [11:0] a);
        psel_i && penable_i && pwrite_i && paddr_i == a;
    endsequence

    property p_ready; pready_o == (psel_i && penable_i); endproperty
    a_ready: assert property (p_ready) else $error("ready wrong");
    property p_slverr;
        s_setup ##1 (s_acc and (paddr_i[11:5] != 7'h00)) |-> pslverr_o;
    endproperty
    a_slverr: assert property (p_slverr) else $error("no slverr");
    property p_dir_wr; s_wr(ppom_pkg::OFF_DIR) |=> pad_oe_o == wd_q;
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("oe load");
    property p_oe_hold;
        !(psel_i && penable_i && pwrite_i && paddr_i == ppom_pkg::OFF_DIR)
            |=> $stable(pad_oe_o);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("oe move");
    property p_pu_dir; (pad_pullup_o & pad_oe_o) == '0; endproperty
    a_pu_dir: assert property (p_pu_dir) else $error("pu and oe");
    property p_out_off; (pad_out_o & ~pad_oe_o) == '0; endproperty
    a_out_off: assert property (p_out_off) else $error("out set");
    property p_toggle;
        s_wr(ppom_pkg::OFF_PIN_IN) |=> pad_out_o == tog_q;
    endproperty
    a_toggle: assert property (p_toggle) else $error("bad flip");
    property p_ien; pin_change_src_o == (pad_in_i & ien); endproperty
    a_ien: assert property (p_ien) else $error("raw tap");
    property p_analog; converter_channels_o == pad_in_i; endproperty
    a_analog: assert property (p_analog) else $error("analog");
endmodule : ppom_port_a_chk

bind ppom_port_a ppom_port_a_chk #(.PINS(PINS)) i_ppom_port_a_chk (
    .ref_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .pslverr_o, .pad_in_i, .pad_out_o, .pad_oe_o,
    .pad_pullup_o, .sleep_mode_i, .pin_change_mask_bits_i,
    .pin_change_group0_en_i, .chan_digital_off_bit_i, .pin_change_src_o,
    .converter_channels_o
);

// file: dv/tb_top.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the Port A override mux
// =====================================================================
module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, lfsr = 32'h46c7;
    logic        pready_o, pslverr_o, pud_m = 1'b0, grp_q = 1'b0, grp;
    logic [7:0]  pad_in_i = 8'h00, pad_out_o, pad_oe_o, pad_pullup_o;
    logic [7:0]  mask_q = 8'h00, off_q = 8'h00, mask, off, src, conv, psync;
    logic [7:0]  dir_m = 8'h00, port_m = 8'h00;
    logic [2:0]  sleep_mode_i = 3'h0;
    logic [48:0] notes[$], got, exp;
    int          n_errors = 0, compares = 0;

    always #25 ref_clk_i = ~ref_clk_i;

    ppom_port_a #(.PINS(8)) i_ppom_port_a (
        .ref_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pad_in_i,
        .pad_out_o, .pad_oe_o, .pad_pullup_o, .sleep_mode_i,
        .pin_change_mask_bits_i(mask), .pin_change_group0_en_i(grp),
        .chan_digital_off_bit_i(off), .pin_change_src_o(src),
        .converter_channels_o(conv));
    ppom_periph_model i_ppom_periph_model (
        .ref_clk_i, .rst_b_i, .mask_req_i(mask_q), .grp_req_i(grp_q),
        .off_req_i(off_q), .pc_raw_i(src), .mask_o(mask), .grp_o(grp),
        .off_o(off), .pc_sync_o(psync));

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // Input enable: override first, otherwise the sleep clamp decides
    function automatic logic [7:0] ien_exp();
        logic [7:0] o, e;
        o = mask_q & {8{grp_q}};
        e = o | off_q;
        return (e & o) |
               (~e & {8{!(sleep_mode_i inside {3'h3, 3'h4, 3'h5})}});
    endfunction : ien_exp

    function automatic logic [31:0] status();
        return {8'h00, ~dir_m & port_m & {8{~pud_m}}, dir_m, ien_exp()};
    endfunction : status

    // One APB transfer; an idle cycle follows so psel never doubles up
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic e);
        notes.push_back({pad_in_i & ien_exp(), dir_m & port_m, e, d});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic report_and_stop();
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // Read results against the oldest note, pad level included
    always @(posedge ref_clk_i) begin
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
            got = {psync, pad_out_o, pslverr_o, prdata_o};
            exp = notes.pop_front();
            compares++;
            if (got !== exp) begin
                n_errors++;
                $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            end
        end
    end

    initial begin
        logic [31:0] r, s;
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        rd(ppom_pkg::OFF_DIR, {24'h0, ppom_pkg::RST_DIR}, 1'b0);
        rd(ppom_pkg::OFF_CTRL, {31'h0, ppom_pkg::RST_PUD}, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        apb(1'b1, ppom_pkg::OFF_STATUS, 32'hffffffff);
        rd(ppom_pkg::OFF_STATUS, status(), 1'b0);
        // Random sweep, every sleep code visited
        for (int i = 0; i < 42; i++) begin
            r = rnd();
            s = rnd();
            pad_in_i     <= r[7:0];
            mask_q       <= r[15:8];
            off_q        <= r[23:16] & {8{r[24]}};
            grp_q        <= r[25];
            sleep_mode_i <= 3'(i % 7);
            dir_m  = s[7:0];
            port_m = s[15:8];
            pud_m  = s[16];
            apb(1'b1, ppom_pkg::OFF_DIR, {24'h0, dir_m});
            apb(1'b1, ppom_pkg::OFF_PORT_OUT, {s[31:24], 16'h0, port_m});
            apb(1'b1, ppom_pkg::OFF_CTRL, {31'h0, pud_m});
            rd(ppom_pkg::OFF_STATUS, status(), 1'b0);
            rd(ppom_pkg::OFF_PIN_IN, {24'h0, pad_in_i & ien_exp()},
               1'b0);
            apb(1'b1, ppom_pkg::OFF_PIN_IN, {24'h0, s[23:16]});
            port_m = port_m ^ s[23:16];
            rd(ppom_pkg::OFF_PORT_OUT, {24'h0, port_m}, 1'b0);
        end
        report_and_stop();
    end

    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_errors++;
        report_and_stop();
    end
endmodule : tb_top

// file: pkg/ppom_pkg.sv
// =====================================================================
// Shared constants for the port pin override multiplexer
// =====================================================================
package ppom_pkg;

    // =================================================================
    // Geometry
    // =================================================================
    localparam int unsigned NUM_PINS   = 8;
    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;

    // =================================================================
    // Register byte offsets (one aligned word each)
    // =================================================================
    localparam logic [11:0] OFF_PIN_IN   = 12'h000; // Read sync, write toggles
    localparam logic [11:0] OFF_DIR      = 12'h004; // Direction bits
    localparam logic [11:0] OFF_PORT_OUT = 12'h008; // Port output bits
    localparam logic [11:0] OFF_CTRL     = 12'h00c; // Global control
    localparam logic [11:0] OFF_STATUS   = 12'h010; // Live pin state

    // =================================================================
    // Field positions
    // =================================================================
    localparam int unsigned CTRL_PUD_BIT      = 0;  // pullups_global_off
    localparam int unsigned STAT_INPUT_EN_LSB = 0;  // Input enables, 8 bits
    localparam int unsigned STAT_DRIVE_EN_LSB = 8;  // Driver enables, 8 bits
    localparam int unsigned STAT_PULLUP_LSB   = 16; // Pull-up enables, 8 bits

    // =================================================================
    // Reset values
    // =================================================================
    localparam logic [7:0] RST_DIR      = 8'h00;
    localparam logic [7:0] RST_PORT_OUT = 8'h00;
    localparam logic       RST_PUD      = 1'b0;
    localparam logic [7:0] RST_PIN_SYNC = 8'h00;

    // =================================================================
    // Sleep controller mode codes
    // =================================================================
    typedef enum logic [2:0] {
        SLP_ACTIVE      = 3'h0,
        SLP_IDLE        = 3'h1,
        SLP_ADC_NR      = 3'h2,
        SLP_POWER_DOWN  = 3'h3,
        SLP_POWER_SAVE  = 3'h4,
        SLP_STANDBY     = 3'h5,
        SLP_EXT_STANDBY = 3'h6
    } ppom_sleep_t;

endpackage : ppom_pkg

// file: verilog/ppom_pin_cell.sv
`timescale 1ns/1ps
// =====================================================================
// One pin: override selection between port control and peripheral
// =====================================================================
module ppom_pin_cell (
    // Port register bits
    input  wire logic dir_bit_i,
    input  wire logic port_out_bit_i,
    input  wire logic pullups_global_off_i,
    // Peripheral override signals
    input  wire logic pullup_override_en_i,
    input  wire logic pullup_override_val_i,
    input  wire logic dir_override_en_i,
    input  wire logic dir_override_val_i,
    input  wire logic value_override_en_i,
    input  wire logic value_override_val_i,
    input  wire logic input_en_override_en_i,
    input  wire logic input_en_override_val_i,
    // Sleep clamp and pad level
    input  wire logic sleep_clamp_i,
    input  wire logic pad_in_i,
    // Pad controls and input taps
    output logic      pullup_en_o,
    output logic      drive_en_o,
    output logic      drive_val_o,
    output logic      input_en_o,
    output logic      alt_raw_input_o
);

    // =================================================================
    // Pad control selection
    // =================================================================
    // Pull-up, driver and value each pick override or port register
    always_comb begin
        if (pullup_override_en_i) begin
            pullup_en_o = pullup_override_val_i;
        end else begin
            pullup_en_o = ({dir_bit_i, port_out_bit_i,
                            pullups_global_off_i} == 3'h2);
        end
        if (dir_override_en_i) begin
            drive_en_o = dir_override_val_i;
        end else begin
            drive_en_o = dir_bit_i;
        end
        // Value is forced low while undriven so the pad output is stable
        if (!drive_en_o) begin
            drive_val_o = 1'b0;
        end else if (value_override_en_i) begin
            drive_val_o = value_override_val_i;
        end else begin
            drive_val_o = port_out_bit_i;
        end
    end

    // =================================================================
    // Digital input enable and raw tap
    // =================================================================
    // Clamped input reads as ground; tap sits ahead of the synchronizer
    always_comb begin
        if (input_en_override_en_i) begin
            input_en_o = input_en_override_val_i;
        end else begin
            input_en_o = !sleep_clamp_i;
        end
        alt_raw_input_o = pad_in_i & input_en_o;
    end

endmodule : ppom_pin_cell

// file: verilog/ppom_port_a.sv
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Pull-up override enable selects override value
// - Else pull-up on when pattern is 010
// - Direction override enable selects override driver value
// - Else driver follows direction register bit
// - Value override drives override level when enabled
// - Else driven level is port output bit
// - Toggle override inverts port output bit
// - Input override enable selects input enable value
// - Else input enable follows run/sleep state
// - Raw input tapped before synchronizer; receiver syncs
// - Port A pull/direction/value overrides tied zero
// - Input override from pin-change and digital-off
// - Raw input feeds same-index pin-change source
// - Analog path feeds same-index converter channel
// - Analog path goes straight to pad
// - Writing one to input bit toggles output
// - Clamp inputs in power-down, power-save, standby
module ppom_port_a #(
    parameter int unsigned PINS = ppom_pkg::NUM_PINS
) (
    // Clock and reset
    input  wire logic                            ref_clk_i,
    input  wire logic                            rst_b_i,
    // APB slave
    input  wire logic                            psel_i,
    input  wire logic                            penable_i,
    input  wire logic                            pwrite_i,
    input  wire logic [ppom_pkg::APB_ADDR_W-1:0] paddr_i,
    input  wire logic [ppom_pkg::APB_DATA_W-1:0] pwdata_i,
    output logic      [ppom_pkg::APB_DATA_W-1:0] prdata_o,
    output logic                                 pready_o,
    output logic                                 pslverr_o,
    // Pads
    input  wire logic [PINS-1:0]                 pad_in_i,
    output logic      [PINS-1:0]                 pad_out_o,
    output logic      [PINS-1:0]                 pad_oe_o,
    output logic      [PINS-1:0]                 pad_pullup_o,
    // Sleep controller
    input  wire logic [2:0]                      sleep_mode_i,
    // Pin-change unit and converter controls
    input  wire logic [PINS-1:0]                 pin_change_mask_bits_i,
    input  wire logic                            pin_change_group0_en_i,
    input  wire logic [PINS-1:0]                 chan_digital_off_bit_i,
    // Taps to alternate-function modules
    output logic      [PINS-1:0]                 pin_change_src_o,
    output logic      [PINS-1:0]                 converter_channels_o
);

    // =================================================================
    // Register state
    // =================================================================
    logic [PINS-1:0]                 dir_bit_q;
    logic [PINS-1:0]                 dir_bit_d;
    logic [PINS-1:0]                 port_out_bit_q;
    logic [PINS-1:0]                 port_out_bit_d;
    logic                            pullups_global_off_q;
    logic                            pullups_global_off_d;
    logic [ppom_pkg::APB_DATA_W-1:0] rdata_q;
    logic [ppom_pkg::APB_DATA_W-1:0] rdata_d;
    logic                            slverr_q;
    logic                            slverr_d;

    // Input synchronizer, two stages
    logic [PINS-1:0]                 pin_meta_q;
    logic [PINS-1:0]                 pin_in_bit_q;

    // =================================================================
    // Per-pin wires
    // =================================================================
    logic [PINS-1:0]                 input_en_override_en;
    logic [PINS-1:0]                 input_en_override_val;
    logic [PINS-1:0]                 toggle_override_en;
    logic [PINS-1:0]                 pullup_en;
    logic [PINS-1:0]                 drive_en;
    logic [PINS-1:0]                 drive_val;
    logic [PINS-1:0]                 input_en;
    logic [PINS-1:0]                 alt_raw_input;
    logic                            sleep_clamp;

    // =================================================================
    // APB decode helpers
    // =================================================================
    logic                            setup_phase;
    logic                            access_phase;
    logic                            wr_pin;
    logic                            wr_dir;
    logic                            wr_port;
    logic                            wr_ctrl;
    logic                            addr_hit;

    // =================================================================
    // Sleep clamp
    // =================================================================
    // Deep sleep modes clamp floating inputs to save current; idle,
    // converter noise reduction and extended standby leave them alone
    always_comb begin
        case (sleep_mode_i)
            ppom_pkg::SLP_POWER_DOWN: sleep_clamp = 1'b1;
            ppom_pkg::SLP_POWER_SAVE: sleep_clamp = 1'b1;
            ppom_pkg::SLP_STANDBY:    sleep_clamp = 1'b1;
            default:                  sleep_clamp = 1'b0;
        endcase
    end

    // =================================================================
    // Port A override generation
    // =================================================================
    // Pin-change wake must see the pad even while clamped, and a pin
    // handed to the converter must have its digital buffer switched
    // off; both are pure gates on the owners' bits, so a change in a
    // mask or disable bit reaches the pad in the same cycle
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            input_en_override_val[i] = pin_change_mask_bits_i[i]
                                     & pin_change_group0_en_i;
            input_en_override_en[i]  = input_en_override_val[i]
                                     | chan_digital_off_bit_i[i];
        end
        // Port A has no peripheral that toggles its output bits
        toggle_override_en = '0;
    end

    // =================================================================
    // Pin cells
    // =================================================================
    // Pull-up, direction and value overrides are held at zero so the
    // port registers keep full control of every Port A pin
    for (genvar g = 0; g < PINS; g++) begin : g_pin
        ppom_pin_cell u_cell (
            .dir_bit_i               (dir_bit_q[g]),
            .port_out_bit_i          (port_out_bit_q[g]),
            .pullups_global_off_i    (pullups_global_off_q),
            .pullup_override_en_i    (1'b0),
            .pullup_override_val_i   (1'b0),
            .dir_override_en_i       (1'b0),
            .dir_override_val_i      (1'b0),
            .value_override_en_i     (1'b0),
            .value_override_val_i    (1'b0),
            .input_en_override_en_i  (input_en_override_en[g]),
            .input_en_override_val_i (input_en_override_val[g]),
            .sleep_clamp_i           (sleep_clamp),
            .pad_in_i                (pad_in_i[g]),
            .pullup_en_o             (pullup_en[g]),
            .drive_en_o              (drive_en[g]),
            .drive_val_o             (drive_val[g]),
            .input_en_o              (input_en[g]),
            .alt_raw_input_o         (alt_raw_input[g])
        );
    end

    // =================================================================
    // Pad outputs and alternate-function taps
    // =================================================================
    // Raw input is unsynchronized; the pin-change unit must sync it
    always_comb begin
        pad_out_o            = drive_val;
        pad_oe_o             = drive_en;
        pad_pullup_o         = pullup_en;
        pin_change_src_o     = alt_raw_input;
        // Analog level comes from the pad, ahead of any digital gating
        converter_channels_o = pad_in_i;
    end

    // =================================================================
    // APB decode
    // =================================================================
    // Reads are captured in the setup cycle so read data leaves a flop;
    // the access phase then completes at once, one wait-free cycle
    always_comb begin
        setup_phase  = psel_i & !penable_i;
        access_phase = psel_i & penable_i;
        wr_pin       = 1'b0;
        wr_dir       = 1'b0;
        wr_port      = 1'b0;
        wr_ctrl      = 1'b0;
        addr_hit     = 1'b1;
        if (paddr_i == ppom_pkg::OFF_PIN_IN) begin
            wr_pin = access_phase & pwrite_i;
        end else if (paddr_i == ppom_pkg::OFF_DIR) begin
            wr_dir = access_phase & pwrite_i;
        end else if (paddr_i == ppom_pkg::OFF_PORT_OUT) begin
            wr_port = access_phase & pwrite_i;
        end else if (paddr_i == ppom_pkg::OFF_CTRL) begin
            wr_ctrl = access_phase & pwrite_i;
        end else if (paddr_i == ppom_pkg::OFF_STATUS) begin
            addr_hit = 1'b1;                                   // Read only
        end else begin
            addr_hit = 1'b0;
        end
    end

    // =================================================================
    // Register next state
    // =================================================================
    // A write of one to the input register flips the output bit no
    // matter the direction; a toggle override flips it every cycle it
    // is held, so the owning module must pulse it
    always_comb begin
        dir_bit_d            = dir_bit_q;
        port_out_bit_d       = port_out_bit_q;
        pullups_global_off_d = pullups_global_off_q;
        if (wr_dir) begin
            dir_bit_d = pwdata_i[PINS-1:0];
        end
        if (wr_port) begin
            port_out_bit_d = pwdata_i[PINS-1:0];
        end
        if (wr_pin) begin
            port_out_bit_d = port_out_bit_q ^ pwdata_i[PINS-1:0];
        end
        port_out_bit_d = port_out_bit_d ^ toggle_override_en;
        if (wr_ctrl) begin
            pullups_global_off_d = pwdata_i[ppom_pkg::CTRL_PUD_BIT];
        end
    end

    // =================================================================
    // Read data and error capture
    // =================================================================
    // Unmapped addresses read zero and flag an error; writes to the
    // status word are ignored without error
    always_comb begin
        rdata_d  = rdata_q;
        slverr_d = slverr_q;
        if (setup_phase) begin
            rdata_d  = '0;
            slverr_d = !addr_hit;
            if (pwrite_i) begin
                rdata_d = '0;
            end else if (paddr_i == ppom_pkg::OFF_PIN_IN) begin
                rdata_d[PINS-1:0] = pin_in_bit_q;
            end else if (paddr_i == ppom_pkg::OFF_DIR) begin
                rdata_d[PINS-1:0] = dir_bit_q;
            end else if (paddr_i == ppom_pkg::OFF_PORT_OUT) begin
                rdata_d[PINS-1:0] = port_out_bit_q;
            end else if (paddr_i == ppom_pkg::OFF_CTRL) begin
                rdata_d[ppom_pkg::CTRL_PUD_BIT] = pullups_global_off_q;
            end else if (paddr_i == ppom_pkg::OFF_STATUS) begin
                rdata_d[ppom_pkg::STAT_INPUT_EN_LSB +: PINS] = input_en;
                rdata_d[ppom_pkg::STAT_DRIVE_EN_LSB +: PINS] = drive_en;
                rdata_d[ppom_pkg::STAT_PULLUP_LSB +: PINS]   = pullup_en;
            end
        end
    end

    // =================================================================
    // APB answer
    // =================================================================
    always_comb begin
        pready_o  = access_phase;
        pslverr_o = access_phase & slverr_q;
        prdata_o  = rdata_q;
    end

    // =================================================================
    // Flops
    // =================================================================
    // Registers, bus capture and the input synchronizer; reset leaves
    // every pin an input with no pull-up, so the pads float tri-state
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_bit_q            <= ppom_pkg::RST_DIR;
            port_out_bit_q       <= ppom_pkg::RST_PORT_OUT;
            pullups_global_off_q <= ppom_pkg::RST_PUD;
            rdata_q              <= '0;
            slverr_q             <= 1'b0;
            pin_meta_q           <= ppom_pkg::RST_PIN_SYNC;
            pin_in_bit_q         <= ppom_pkg::RST_PIN_SYNC;
        end else begin
            dir_bit_q            <= dir_bit_d;
            port_out_bit_q       <= port_out_bit_d;
            pullups_global_off_q <= pullups_global_off_d;
            rdata_q              <= rdata_d;
            slverr_q             <= slverr_d;
            pin_meta_q           <= alt_raw_input;
            pin_in_bit_q         <= pin_meta_q;
        end
    end

endmodule : ppom_port_a
